/* src/itrl_defs.svh */
`ifndef ITRL_DEFS_SVH
`define ITRL_DEFS_SVH
// port offsets from the timer base (counter n at n, control word at 3)
`define ITRL_CTRL_ADDR 2'h3
// control word fields
`define ITRL_SEL_HI 7
`define ITRL_SEL_LO 6
`define ITRL_RW_HI 5
`define ITRL_RW_LO 4
`define ITRL_MODE_HI 3
`define ITRL_MODE_LO 1
`define ITRL_BCD_BIT 0
// read-back fields
`define ITRL_RB_NOCNT 5
`define ITRL_RB_NOSTS 4
`define ITRL_RB_SEL0 1
// encodings
`define ITRL_SEL_RB 2'h3
`define ITRL_RW_LATCH 2'h0
`define ITRL_RW_LSB 2'h1
`define ITRL_RW_MSB 2'h2
`define ITRL_RW_BOTH 2'h3
// reset programming
`define ITRL_RST_RW 2'h3
`define ITRL_RST_MODE 3'h0
`define ITRL_RST_BCD 1'h0
`define ITRL_ZERO_BYTE 8'h00
`endif

/* src/itrl_pkg.sv */
package itrl_pkg;
   typedef enum logic [1:0] {
      ITRL_CMD_NONE = 2'b00,
      ITRL_CMD_READBACK = 2'b01,
      ITRL_CMD_LATCH = 2'b10,
      ITRL_CMD_PROGRAM = 2'b11
   } itrl_cmd_e;

   typedef struct packed {
      logic [2:0][15:0] cnt_latch;
      logic [2:0] cnt_full;
      logic [2:0][7:0] sts_latch;
      logic [2:0] sts_full;
      logic [2:0] rd_hi;
      logic [2:0][1:0] rw_sel;
      logic [2:0][2:0] mode;
      logic [2:0] bcd;
      logic [7:0] rdata;
      logic rvalid;
   } itrl_state_s;
endpackage

/* src/itrl_readback.sv */
// Behaviour
// R01 - control word with top bits 11 is a read-back command
// R02 - read-back freezes status and/or count; later port reads return frozen values
// R03 - read-back bit 5 clear freezes count of selected counters
// R04 - read-back bit 4 clear freezes status of selected counters
// R05 - bits 3,2,1 select counters 2,1,0; unselected counters untouched
// R06 - software writes zero to reserved bits of both commands
// R07 - bits 5:4 equal 00 is a counter latch command; reads return frozen count
// R08 - latch command top bits 00,01,10 choose counter 0,1,2
// R09 - latch captures the count of the command cycle; counting continues
// R10 - latch on a counter still holding an unread frozen count is ignored
// R11 - two-byte counts read in two accesses; pointer kept per counter
// R12 - software must not interleave routines reading the same counter
// R13 - read-back captures count, mode, output level, null-count flag
// R14 - frozen status returned on next read of the counter port
// R15 - status bit 7 is the output pin level at capture
// R16 - status bit 6 is the null-count flag
// R17 - status 5:4 byte access, 3:1 mode, 0 bcd
// R18 - status byte first, then frozen count bytes, then live count
// R19 - all frozen bytes read releases the counter latches
`timescale 1ns/1ns
`include "itrl_defs.svh"
module itrl_readback
   import itrl_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // timer port access
   input wire logic [1:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   // counter core state
   input wire logic [2:0][15:0] cnt_value,
   input wire logic [2:0] out_level,
   input wire logic [2:0] null_count,
   // programming to counter core
   output logic [2:0][1:0] prog_rw_sel,
   output logic [2:0][2:0] prog_mode,
   output logic [2:0] prog_bcd
);
   itrl_state_s s;
   itrl_state_s next_s;
   itrl_cmd_e cmd;
   logic [1:0] sel;

   function automatic logic [7:0] itrl_status(input logic out_l, input logic null_c,
      input logic [1:0] rw, input logic [2:0] md, input logic bc);
      itrl_status = {out_l, null_c, rw, md, bc}; // R15 R16 R17
   endfunction

   assign sel = io_wdata[`ITRL_SEL_HI:`ITRL_SEL_LO];

   always_comb
   begin
      cmd = ITRL_CMD_NONE;
      if (io_wr && io_addr == `ITRL_CTRL_ADDR)
      begin
         if (sel == `ITRL_SEL_RB)
            cmd = ITRL_CMD_READBACK; // R01
         else if (io_wdata[`ITRL_RW_HI:`ITRL_RW_LO] == `ITRL_RW_LATCH)
            cmd = ITRL_CMD_LATCH; // R07
         else
            cmd = ITRL_CMD_PROGRAM;
      end
   end

   always_comb
   begin
      logic [7:0] byte_v;
      logic [15:0] val;
      byte_v = `ITRL_ZERO_BYTE;
      val = cnt_value[0];
      next_s = s;
      next_s.rvalid = 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         case (cmd)
            ITRL_CMD_READBACK:
            begin
               if (io_wdata[`ITRL_RB_SEL0 + i]) // R05
               begin
                  if (!io_wdata[`ITRL_RB_NOCNT] && !s.cnt_full[i]) // R03 R10
                  begin
                     next_s.cnt_latch[i] = cnt_value[i]; // R13
                     next_s.cnt_full[i] = 1'b1;
                  end
                  if (!io_wdata[`ITRL_RB_NOSTS] && !s.sts_full[i]) // R04
                  begin
                     next_s.sts_latch[i] = itrl_status(out_level[i], null_count[i],
                        s.rw_sel[i], s.mode[i], s.bcd[i]); // R13
                     next_s.sts_full[i] = 1'b1;
                  end
               end
            end
            ITRL_CMD_LATCH:
            begin
               if (sel == 2'(i) && !s.cnt_full[i]) // R08 R10
               begin
                  next_s.cnt_latch[i] = cnt_value[i]; // R09
                  next_s.cnt_full[i] = 1'b1;
               end
            end
            ITRL_CMD_PROGRAM:
            begin
               if (sel == 2'(i))
               begin
                  next_s.rw_sel[i] = io_wdata[`ITRL_RW_HI:`ITRL_RW_LO];
                  next_s.mode[i] = io_wdata[`ITRL_MODE_HI:`ITRL_MODE_LO];
                  next_s.bcd[i] = io_wdata[`ITRL_BCD_BIT];
                  next_s.rd_hi[i] = 1'b0;
                  next_s.cnt_full[i] = 1'b0;
                  next_s.sts_full[i] = 1'b0;
               end
            end
            default:
            begin
            end
         endcase
      end
      if (io_rd)
      begin
         next_s.rvalid = 1'b1;
         next_s.rdata = `ITRL_ZERO_BYTE;
         for (int i = 0; i < 3; i++)
         begin
            if (io_addr == 2'(i))
            begin
               if (s.sts_full[i])
               begin
                  next_s.rdata = s.sts_latch[i]; // R14 R18
                  next_s.sts_full[i] = 1'b0;
               end
               else
               begin
                  val = s.cnt_full[i] ? s.cnt_latch[i] : cnt_value[i]; // R02 R18
                  if (s.rw_sel[i] == `ITRL_RW_MSB ||
                     (s.rw_sel[i] == `ITRL_RW_BOTH && s.rd_hi[i]))
                     byte_v = val[15:8];
                  else
                     byte_v = val[7:0];
                  next_s.rdata = byte_v;
                  if (s.rw_sel[i] == `ITRL_RW_BOTH)
                     next_s.rd_hi[i] = !s.rd_hi[i]; // R11
                  if (s.cnt_full[i] && (s.rw_sel[i] != `ITRL_RW_BOTH || s.rd_hi[i]))
                     next_s.cnt_full[i] = 1'b0; // R19
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         s <= '0;
         for (int i = 0; i < 3; i++)
         begin
            s.rw_sel[i] <= `ITRL_RST_RW;
            s.mode[i] <= `ITRL_RST_MODE;
            s.bcd[i] <= `ITRL_RST_BCD;
         end
      end
      else
         s <= next_s;
   end

   assign io_rdata = s.rdata;
   assign io_rvalid = s.rvalid;
   assign prog_rw_sel = s.rw_sel;
   assign prog_mode = s.mode;
   assign prog_bcd = s.bcd;

   a_read_answers: assert property (@(posedge core_clk) disable iff (!rst_n) // R02
      io_rd |=> io_rvalid ##1 !io_rvalid || $past(io_rd))
      else $error("read not answered next cycle");

   for (genvar g = 0; g < 3; g++)
   begin : g_chk
      a_rb_count: assert property (@(posedge core_clk) disable iff (!rst_n) // R03
         (cmd == ITRL_CMD_READBACK && io_wdata[`ITRL_RB_SEL0 + g] &&
         !io_wdata[`ITRL_RB_NOCNT] && !s.cnt_full[g] && !io_rd)
         |=> s.cnt_full[g] && s.cnt_latch[g] == $past(cnt_value[g]))
         else $error("read-back count not captured");
      a_rb_status: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
         (cmd == ITRL_CMD_READBACK && io_wdata[`ITRL_RB_SEL0 + g] &&
         !io_wdata[`ITRL_RB_NOSTS] && !s.sts_full[g] && !io_rd)
         |=> s.sts_latch[g][7] == $past(out_level[g]) &&
         s.sts_latch[g][6] == $past(null_count[g]) && s.sts_full[g])
         else $error("status pin or null flag wrong");
      a_unsel_keep: assert property (@(posedge core_clk) disable iff (!rst_n) // R05
         (cmd == ITRL_CMD_READBACK && !io_wdata[`ITRL_RB_SEL0 + g] && !s.cnt_full[g])
         |=> !s.cnt_full[g])
         else $error("unselected counter frozen");
      a_latch_hold: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
         (cmd == ITRL_CMD_LATCH && sel == g && s.cnt_full[g])
         |=> $stable(s.cnt_latch[g]))
         else $error("second latch overwrote count");
      a_sts_first: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
         (io_rd && io_addr == g && s.sts_full[g] && cmd == ITRL_CMD_NONE)
         |=> io_rdata == $past(s.sts_latch[g]) && !s.sts_full[g] && $stable(s.cnt_full[g]))
         else $error("status not returned first");
      a_two_release: assert property (@(posedge core_clk) disable iff (!rst_n) // R19
         (io_rd && io_addr == g && !s.sts_full[g] && s.cnt_full[g] &&
         s.rw_sel[g] == `ITRL_RW_BOTH && s.rd_hi[g] && cmd == ITRL_CMD_NONE)
         |=> !s.cnt_full[g] && io_rdata == $past(s.cnt_latch[g][15:8]))
         else $error("second byte did not release latch");
   end
endmodule

/* testbench/itrl_readback_test.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module itrl_readback_test;
   logic core_clk = 0;
   logic rst_n = 0;
   logic [1:0] io_addr = 0;
   logic io_wr = 0;
   logic io_rd = 0;
   logic [7:0] io_wdata = 0;
   logic [7:0] io_rdata;
   logic io_rvalid;
   logic [2:0][15:0] cnt_value = '0;
   logic [2:0] out_level = 0;
   logic [2:0] null_count = 0;
   logic [2:0][1:0] prog_rw_sel;
   logic [2:0][2:0] prog_mode;
   logic [2:0] prog_bcd;
   int n_errors = 0;
   int cmp_count = 0;
   logic [31:0] seed = 32'd26389;
   logic [7:0] expq[$];
   logic [7:0] e;
   logic [2:0][15:0] cv = '0;
   logic [1:0] rw[3] = '{2'h3, 2'h1, 2'h3};
   logic [2:0] md[3] = '{3'h2, 3'h3, 3'h0};
   logic bc[3] = '{1'b0, 1'b1, 1'b0};
   logic [7:0] st[3];
   logic [15:0] v[3];
   logic [7:0] sv[3];
   logic [7:0] want;
   itrl_readback dut (.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
      .cnt_value(cnt_value), .out_level(out_level), .null_count(null_count),
      .prog_rw_sel(prog_rw_sel), .prog_mode(prog_mode), .prog_bcd(prog_bcd));
   initial
   begin
      forever #2 core_clk = ~core_clk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // new live core state with every write; status snapshot kept
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      for (int i = 0; i < 3; i++)
      begin
         cv[i] = 16'(xs());
         st[i] = {1'(xs()), 1'(xs()), rw[i], md[i], bc[i]};
      end
      cnt_value <= cv;
      out_level <= {st[2][7], st[1][7], st[0][7]};
      null_count <= {st[2][6], st[1][6], st[0][6]};
      io_addr <= a;
      io_wdata <= d;
      io_wr <= 1'b1;
      @(posedge core_clk);
      io_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] x);
      io_addr <= a;
      io_rd <= 1'b1;
      expq.push_back(x);
      @(posedge core_clk);
      io_rd <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rdcnt(input logic [1:0] a, input logic [15:0] x);
      if (rw[a] != 2'h2) rd(a, x[7:0]);
      if (rw[a] != 2'h1) rd(a, x[15:8]);
   endtask
   always @(posedge core_clk)
   begin
      if (rst_n && io_rvalid === 1'b1)
      begin
         want = (expq.size() > 0) ? expq.pop_front() : 8'hxx;
         `CHK(io_rdata, want)
      end
   end
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 3; i++)
         `CHK({prog_rw_sel[i], prog_mode[i], prog_bcd[i]}, 6'h30)
      wr(2'h3, 8'h34);
      wr(2'h3, 8'h57);
      for (int i = 0; i < 3; i++)
         `CHK({prog_rw_sel[i], prog_mode[i], prog_bcd[i]}, {rw[i], md[i], bc[i]})
      $display("programming done");
      wr(2'h3, 8'h00);
      v[0] = cv[0];
      wr(2'h3, 8'h80);
      v[2] = cv[2];
      wr(2'h3, 8'h00);
      rd(2'h0, v[0][7:0]);
      rd(2'h2, v[2][7:0]);
      rd(2'h0, v[0][15:8]);
      rd(2'h2, v[2][15:8]);
      rdcnt(2'h0, cv[0]);
      wr(2'h3, 8'h40);
      v[1] = cv[1];
      wr(2'h1, 8'h00);
      rdcnt(2'h1, v[1]);
      rdcnt(2'h1, cv[1]);
      $display("latch done");
      wr(2'h3, 8'hce);
      v = '{cv[0], cv[1], cv[2]};
      sv = st;
      wr(2'h0, 8'h00);
      rd(2'h0, sv[0]);
      rdcnt(2'h0, v[0]);
      rdcnt(2'h0, cv[0]);
      rd(2'h3, 8'h00);
      // counter 1 still frozen: this latch is ignored
      wr(2'h3, 8'h40);
      // counters 1, 2 still frozen: only counter 0 captures
      wr(2'h3, 8'hce);
      e = st[0];
      v[0] = cv[0];
      rd(2'h2, sv[2]);
      rdcnt(2'h2, v[2]);
      rd(2'h1, sv[1]);
      rdcnt(2'h1, v[1]);
      wr(2'h3, 8'he4);
      sv[1] = st[1];
      wr(2'h3, 8'hd8);
      v[2] = cv[2];
      wr(2'h0, 8'h00);
      rd(2'h1, sv[1]);
      rdcnt(2'h1, cv[1]);
      rdcnt(2'h2, v[2]);
      rd(2'h0, e);
      rdcnt(2'h0, v[0]);
      rdcnt(2'h0, cv[0]);
      $display("read-back done");
      for (int i = 0; i < 20 && expq.size() > 0; i++) @(posedge core_clk);
      if (expq.size() > 0) n_errors++;
      conclude();
   end
endmodule
